// file: pmd_defs.svh
// Register offsets, field positions and reset values of the peripheral disable block.
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH
`define CTRL1_ADDR 12'h000
`define CTRL1_RESET 16'h0000
`define BIT_TIMER5 15
`define BIT_TIMER4 14
`define BIT_TIMER3 13
`define BIT_TIMER2 12
`define BIT_TIMER1 11
`define BIT_ENCODER 10
`define BIT_PULSE 9
`define BIT_UNUSED8 8
`define BIT_I2C1 7
`define BIT_UART2 6
`define BIT_UART1 5
`define BIT_SPI2 4
`define BIT_SPI1 3
`define BIT_UNUSED2 2
`define BIT_CAN 1
`define BIT_ADC 0
`define WORD_LSBS 2
`define ZERO_WORD 32'h0000_0000
`endif

// file: pmd_pkg.sv
// Types shared by the peripheral disable block.
`default_nettype none
package pmd_pkg;
  typedef struct packed {
    logic [15:0] ctrl1;
  } state_type;
  typedef enum logic [1:0] {
    acc_idle = 2'h1,
    acc_done = 2'h2
  } acc_type;
  typedef struct packed {
    logic [31:0] rdata;
    logic [15:0] shadow;
  } bus_state_type;
endpackage : pmd_pkg
`default_nettype wire

// file: disable_if.sv
// Interface that carries the write strobe and control word between bus slave and register.
`timescale 1ns/100ps
`default_nettype none
interface disable_if;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] ctrl1;
  modport slave (output wr_en, output wr_data, input ctrl1);
  modport regs (input wr_en, input wr_data, output ctrl1);
endinterface : disable_if
`default_nettype wire

// file: disable_reg.sv
// Control word holding the per-peripheral disable bits.
`timescale 1ns/100ps
`default_nettype none
`include "pmd_defs.svh"
module disable_reg #(
  parameter bit has_motor = 1'b1,
  parameter bit has_can = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  disable_if.regs bus
);
  pmd_pkg::state_type state_q;
  pmd_pkg::state_type state_d;
  logic [15:0] impl_mask;

  // Unimplemented positions are masked so they can never hold a one.
  always_comb begin
    impl_mask = 16'hffff;
    impl_mask[`BIT_UNUSED8] = 1'b0;
    impl_mask[`BIT_UNUSED2] = 1'b0;
    impl_mask[`BIT_ENCODER] = has_motor;
    impl_mask[`BIT_PULSE] = has_motor;
    impl_mask[`BIT_CAN] = has_can;
  end

  always_comb begin
    state_d = state_q;
    if (bus.wr_en) begin
      state_d.ctrl1 = bus.wr_data & impl_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '{ctrl1: `CTRL1_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign bus.ctrl1 = state_q.ctrl1;

  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !state_q.ctrl1[`BIT_UNUSED8] && !state_q.ctrl1[`BIT_UNUSED2])
    else $error("unimplemented disable bit holds one");
  a_variant_bits: assert property (@(posedge pclk) disable iff (!presetn)
    has_motor || (!state_q.ctrl1[`BIT_ENCODER] && !state_q.ctrl1[`BIT_PULSE]))
    else $error("motor bits set on a variant without them");
  a_can_variant: assert property (@(posedge pclk) disable iff (!presetn)
    has_can || !state_q.ctrl1[`BIT_CAN])
    else $error("can bit set on a variant without it");
  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    bus.wr_en |=> state_q.ctrl1 == ($past(bus.wr_data) & $past(impl_mask)))
    else $error("written value not stored");
endmodule : disable_reg
`default_nettype wire

// file: peripheral_disable.sv
// APB slave holding the peripheral module disable control word and its outputs.
`timescale 1ns/100ps
`default_nettype none
`include "pmd_defs.svh"
// How it works
// - Bit 15 set disables timer 5; clear keeps it enabled.
// - Bit 14 set disables timer 4; clear keeps it enabled.
// - Bit 13 set disables timer 3; clear keeps it enabled.
// - Bit 12 set disables timer 2; clear keeps it enabled.
// - Bit 11 set disables timer 1; clear keeps it enabled.
// - Bit 10 set disables the encoder interface.
// - Bit 9 set disables the pulse generator.
// - Bit 8 is unimplemented and always reads zero.
// - Bit 7 set disables the first I2C controller.
// - Bit 6 set disables the second UART.
// - Bit 5 set disables the first UART.
// - Bit 4 set disables the second SPI port.
// - Encoder and pulse bits exist only on motor-control variants.
// - The CAN bit exists only on variants with a CAN controller.
module peripheral_disable #(
  parameter bit has_motor = 1'b1,
  parameter bit has_can = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer5_off,
  output logic timer4_off,
  output logic timer3_off,
  output logic timer2_off,
  output logic timer1_off,
  output logic encoder_if_off,
  output logic pulse_gen_off,
  output logic i2c_port1_off,
  output logic uart_port2_off,
  output logic uart_port1_off,
  output logic spi_port2_off,
  output logic spi_port1_off,
  output logic can_ctrl_off,
  output logic adc_unit_off
);
  disable_if dif ();
  pmd_pkg::bus_state_type bus_q;
  pmd_pkg::bus_state_type bus_d;
  logic hit;
  logic access;
  logic setup;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] ctrl;
  logic [15:0] merged;
  logic [15:0] read_image;
  logic [15:0] impl_bits;
  logic [15:0] off_image;

  disable_reg #(
    .has_motor(has_motor),
    .has_can(has_can)
  ) u_reg (
    .pclk(pclk),
    .presetn(presetn),
    .bus(dif.regs)
  );

  assign ctrl = dif.ctrl1;
  // Only the word index is decoded; the two byte-offset bits are ignored.
  assign hit = ({paddr[11:`WORD_LSBS], {`WORD_LSBS{1'b0}}} == `CTRL1_ADDR);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_hit = access && pwrite && hit;
  assign rd_hit = !pwrite && hit;

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  // Unmapped addresses answer with an error and change nothing.
  assign pslverr = access && !hit;

  // Byte strobes merge only the enabled halves of the 16-bit word.
  always_comb begin
    merged = ctrl;
    if (pstrb[0]) begin
      merged[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      merged[15:8] = pwdata[15:8];
    end
  end

  assign dif.wr_en = wr_hit;
  assign dif.wr_data = merged;

  // The read image is captured in the setup cycle, so prdata comes from a flip-flop and the
  // slave still needs no wait state: nothing can write the word between setup and access.
  always_comb begin
    read_image = ctrl;
    read_image[`BIT_UNUSED8] = 1'b0;
    read_image[`BIT_UNUSED2] = 1'b0;
  end

  // The shadow word is a second, independent copy of the written bits, kept unmasked, that only the
  // assertions read; it has no load, so synthesis drops it.
  always_comb begin
    bus_d = bus_q;
    if (setup) begin
      bus_d.rdata = `ZERO_WORD;
      if (rd_hit) begin
        bus_d.rdata[15:0] = read_image;
      end
    end
    if (wr_hit && pstrb[0]) begin
      bus_d.shadow[7:0] = pwdata[7:0];
    end
    if (wr_hit && pstrb[1]) begin
      bus_d.shadow[15:8] = pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= '{rdata: `ZERO_WORD, shadow: `CTRL1_RESET};
    end else begin
      bus_q <= bus_d;
    end
  end

  assign prdata = bus_q.rdata;

  assign timer5_off = ctrl[`BIT_TIMER5];
  assign timer4_off = ctrl[`BIT_TIMER4];
  assign timer3_off = ctrl[`BIT_TIMER3];
  assign timer2_off = ctrl[`BIT_TIMER2];
  assign timer1_off = ctrl[`BIT_TIMER1];
  assign encoder_if_off = ctrl[`BIT_ENCODER];
  assign pulse_gen_off = ctrl[`BIT_PULSE];
  assign i2c_port1_off = ctrl[`BIT_I2C1];
  assign uart_port2_off = ctrl[`BIT_UART2];
  assign uart_port1_off = ctrl[`BIT_UART1];
  assign spi_port2_off = ctrl[`BIT_SPI2];
  assign spi_port1_off = ctrl[`BIT_SPI1];
  assign can_ctrl_off = ctrl[`BIT_CAN];
  assign adc_unit_off = ctrl[`BIT_ADC];

  // Which positions this variant implements, worked out apart from the register's own mask.
  always_comb begin
    impl_bits = 16'hffff;
    impl_bits[`BIT_UNUSED8] = 1'b0;
    impl_bits[`BIT_UNUSED2] = 1'b0;
    impl_bits[`BIT_ENCODER] = has_motor;
    impl_bits[`BIT_PULSE] = has_motor;
    impl_bits[`BIT_CAN] = has_can;
  end

  // The disable outputs gathered back into register order for the model check.
  always_comb begin
    off_image = 16'h0000;
    off_image[`BIT_TIMER5] = timer5_off;
    off_image[`BIT_TIMER4] = timer4_off;
    off_image[`BIT_TIMER3] = timer3_off;
    off_image[`BIT_TIMER2] = timer2_off;
    off_image[`BIT_TIMER1] = timer1_off;
    off_image[`BIT_ENCODER] = encoder_if_off;
    off_image[`BIT_PULSE] = pulse_gen_off;
    off_image[`BIT_I2C1] = i2c_port1_off;
    off_image[`BIT_UART2] = uart_port2_off;
    off_image[`BIT_UART1] = uart_port1_off;
    off_image[`BIT_SPI2] = spi_port2_off;
    off_image[`BIT_SPI1] = spi_port1_off;
    off_image[`BIT_CAN] = can_ctrl_off;
    off_image[`BIT_ADC] = adc_unit_off;
  end

  sequence s_write_t5(v);
    psel && penable && pwrite && hit && pstrb[1] && pwdata[`BIT_TIMER5] == v;
  endsequence

  sequence s_write_high;
    wr_hit && pstrb[1];
  endsequence

  sequence s_write_low;
    wr_hit && pstrb[0];
  endsequence

  sequence s_read_hit;
    access && rd_hit;
  endsequence

  a_timer5_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_t5(1'b1) |=> timer5_off)
    else $error("timer 5 not disabled after write");
  a_timer5_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_t5(1'b0) |=> !timer5_off)
    else $error("timer 5 not enabled after write");
  a_timer4_track: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit && pstrb[1]) |=> timer4_off == $past(pwdata[`BIT_TIMER4]))
    else $error("timer 4 disable mismatch");
  a_timer1_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite) |=> $stable(timer1_off))
    else $error("timer 1 disable changed without write");
  a_uart1_track: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit && pstrb[0]) |=> uart_port1_off == $past(pwdata[`BIT_UART1]))
    else $error("uart 1 disable mismatch");
  a_read_zero8: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit) |-> !prdata[`BIT_UNUSED8] && prdata[31:16] == 16'h0000)
    else $error("unimplemented bits read nonzero");
  a_adc_track: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit && pstrb[0]) |=> adc_unit_off == $past(pwdata[`BIT_ADC]))
    else $error("adc disable mismatch");
  a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && !hit) |=> $stable(ctrl))
    else $error("unmapped write changed the control word");

  // Every implemented disable output follows its written bit from the edge after the write.
  a_timer3_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_high |=> timer3_off == $past(pwdata[`BIT_TIMER3]))
    else $error("timer 3 disable mismatch");
  a_timer2_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_high |=> timer2_off == $past(pwdata[`BIT_TIMER2]))
    else $error("timer 2 disable mismatch");
  a_timer1_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_high |=> timer1_off == $past(pwdata[`BIT_TIMER1]))
    else $error("timer 1 disable mismatch");
  a_encoder_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_high |=> encoder_if_off == ($past(pwdata[`BIT_ENCODER]) && has_motor))
    else $error("encoder disable mismatch");
  a_pulse_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_high |=> pulse_gen_off == ($past(pwdata[`BIT_PULSE]) && has_motor))
    else $error("pulse generator disable mismatch");
  a_i2c1_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_low |=> i2c_port1_off == $past(pwdata[`BIT_I2C1]))
    else $error("i2c 1 disable mismatch");
  a_uart2_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_low |=> uart_port2_off == $past(pwdata[`BIT_UART2]))
    else $error("uart 2 disable mismatch");
  a_spi2_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_low |=> spi_port2_off == $past(pwdata[`BIT_SPI2]))
    else $error("spi 2 disable mismatch");
  a_spi1_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_low |=> spi_port1_off == $past(pwdata[`BIT_SPI1]))
    else $error("spi 1 disable mismatch");
  a_can_track: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_low |=> can_ctrl_off == ($past(pwdata[`BIT_CAN]) && has_can))
    else $error("can disable mismatch");

  // A byte lane with its strobe low keeps its bits, and nothing changes between writes.
  a_high_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_hit && !pstrb[1]) |=> $stable(ctrl[15:8]))
    else $error("high byte changed with its strobe low");
  a_low_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_hit && !pstrb[0]) |=> $stable(ctrl[7:0]))
    else $error("low byte changed with its strobe low");
  a_idle_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_hit |=> $stable(ctrl))
    else $error("control word changed without a write");

  // Reads return the stored word from the first access cycle, with unused bits at zero.
  a_read_image: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_hit |-> prdata == {16'h0000, ctrl})
    else $error("read data differs from the stored word");
  a_read_zero2: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_hit |-> !prdata[`BIT_UNUSED2])
    else $error("unimplemented bit 2 reads one");
  a_read_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && !hit) |-> prdata == `ZERO_WORD)
    else $error("unmapped read returned data");
  a_setup_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !rd_hit) |=> prdata == `ZERO_WORD)
    else $error("read data not cleared for a non-read");
  a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> $stable(prdata))
    else $error("read data changed after an access");

  // The slave never stalls and flags exactly the accesses that miss the register.
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    psel |-> pready)
    else $error("slave inserted a wait state");
  a_miss_error: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !hit) |-> pslverr)
    else $error("unmapped access not flagged");
  a_hit_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    (access && hit) |-> !pslverr)
    else $error("mapped access flagged as error");
  a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !access |-> !pslverr)
    else $error("error flag raised outside an access");

  // Reset clears the word and the read data even before it is released.
  a_reset_clear: assert property (@(posedge pclk)
    !presetn |-> ctrl == `CTRL1_RESET && prdata == `ZERO_WORD)
    else $error("reset left the word or read data set");

  // The outputs must match the independent shadow copy under the variant's mask.
  a_model_match: assert property (@(posedge pclk) disable iff (!presetn)
    off_image == (bus_q.shadow & impl_bits))
    else $error("disable outputs differ from the shadow copy");
endmodule : peripheral_disable
`default_nettype wire

// file: peripheral_disable_tb_top.sv
// Self-checking bench for the peripheral disable register block.
`timescale 1ns/100ps
`default_nettype none
`include "pmd_defs.svh"
module peripheral_disable_tb_top;
  logic pclk = 1'h0;
  logic presetn;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  wire logic [31:0] prdata;
  wire logic [31:0] prdata_var;
  wire logic pready;
  wire logic pslverr;
  wire logic [15:0] offs;
  wire logic [2:0] var_offs;
  wire logic [31:0] o32 = {16'h0000, offs};
  logic [31:0] rd;
  logic [31:0] rd_var;
  logic [31:0] e;
  logic err;
  int n_fail = 0;
  int comparisons = 0;
  assign offs[8] = 1'h0;
  assign offs[2] = 1'h0;
  always #20 pclk = ~pclk;
  peripheral_disable u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .timer5_off(offs[15]), .timer4_off(offs[14]),
    .timer3_off(offs[13]), .timer2_off(offs[12]), .timer1_off(offs[11]),
    .encoder_if_off(offs[10]), .pulse_gen_off(offs[9]), .i2c_port1_off(offs[7]),
    .uart_port2_off(offs[6]), .uart_port1_off(offs[5]), .spi_port2_off(offs[4]),
    .spi_port1_off(offs[3]), .can_ctrl_off(offs[1]), .adc_unit_off(offs[0]));
  // A variant without motor and CAN bits shares the bus, so one transfer checks both.
  peripheral_disable #(.has_motor(1'h0), .has_can(1'h0)) u_var (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_var), .pready(), .pslverr(),
    .timer5_off(), .timer4_off(), .timer3_off(), .timer2_off(), .timer1_off(),
    .encoder_if_off(var_offs[2]), .pulse_gen_off(var_offs[1]), .i2c_port1_off(),
    .uart_port2_off(), .uart_port1_off(), .spi_port2_off(), .spi_port1_off(),
    .can_ctrl_off(var_offs[0]), .adc_unit_off());
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    rd_var = prdata_var;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    // An edge into reset is needed: an initialised low level would never fire the reset branch.
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
    chk("reset value", rd, {16'h0000, `CTRL1_RESET});
    chk("reset outputs", o32, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      apb(1'h1, `CTRL1_ADDR, 32'h0000_0001 << i, 4'h3);
      apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
      e = (32'h0000_0001 << i) & 32'h0000_fefb;
      chk("readback", rd, e);
      chk("timers", o32 & 32'h0000_f800, e & 32'h0000_f800);
      chk("motor", o32 & 32'h0000_0600, e & 32'h0000_0600);
      chk("comms", o32 & 32'h0000_00ff, e & 32'h0000_00ff);
      chk("variant", rd_var, (32'h0000_0001 << i) & 32'h0000_f8f9);
    end
    apb(1'h1, `CTRL1_ADDR, 32'hffff_ffff, 4'h3);
    apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
    chk("all set", rd, 32'h0000_fefb);
    chk("variant all", rd_var, 32'h0000_f8f9);
    chk("variant outputs", {29'h0, var_offs}, 32'h0000_0000);
    apb(1'h1, `CTRL1_ADDR, 32'h0000_0000, 4'h1);
    apb(1'h1, 12'h004, 32'h0000_0000, 4'h3);
    chk("unmapped write error", {31'h0, err}, 32'h0000_0001);
    apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
    chk("low lane only", rd, 32'h0000_fe00);
    apb(1'h0, 12'h004, 32'h0000_0000, 4'h0);
    chk("unmapped read data", rd, 32'h0000_0000);
    chk("unmapped read error", {31'h0, err}, 32'h0000_0001);
    apb(1'h1, `CTRL1_ADDR, 32'h0000_a5ff, 4'h2);
    apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
    chk("high lane only", rd, 32'h0000_a400);
    chk("variant high lane", rd_var, 32'h0000_a000);
    chk("high lane outputs", o32, 32'h0000_a400);
    presetn <= 1'h0;
    @(posedge pclk);
    chk("mid reset outputs", o32, 32'h0000_0000);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `CTRL1_ADDR, 32'h0000_0000, 4'h0);
    chk("after reset", rd, 32'h0000_0000);
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule : peripheral_disable_tb_top
`default_nettype wire
